// File: pdcd_regs.svh
// Register offsets, reset values and record layout for the peak detect and deglitch block
`ifndef PDCD_REGS_SVH
`define PDCD_REGS_SVH
`define PDCD_REC_FIRST     8'h10
`define PDCD_REC_LAST      8'h2F
`define PDCD_OC_FILT_ADDR  8'h6A
`define PDCD_UV_FILT_ADDR  8'h6B
`define PDCD_OV_FILT_ADDR  8'h6C
`define PDCD_FREEZE_ADDR   8'h74
`define PDCD_CLEAR_ADDR    8'h73
`define PDCD_CTRL_RESET    8'h00
`define PDCD_OC_VALID_MASK 8'h0F
`define PDCD_MIN_RESET     10'h3FF
`define PDCD_MAX_RESET     10'h000
`define PDCD_CMP_UV1       0
`define PDCD_CMP_UV2       1
`define PDCD_CMP_OV1       2
`define PDCD_CMP_OV2       3
`define PDCD_CMP_OC        4
`endif

// File: pdcd_pkg.sv
// Types shared by the peak detect and deglitch block
package pdcd_pkg;
   // One converted sample; sel = 2*channel + (1 for voltage, 0 for current)
   typedef struct packed {
      logic       valid;
      logic [2:0] sel;
      logic [9:0] data;
   } pdcd_sample_t;
   // One byte-wide register access
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pdcd_reg_req_t;
endpackage

// File: pdcd_top.sv
// Min/max peak records and comparator deglitch filters for a four-channel monitor
//
// Functional notes
// [RQ1] Writing 1 to a signal's clear bit resets that signal's min and max records at 0x10-0x2F.
// [RQ2] A cleared minimum record reads 0x3FF and a cleared maximum record reads 0x000.
// [RQ3] While a clear bit stays 1 the signal's detection is off and its records sit at reset.
// [RQ4] A freeze bit of 1 stops updates of that signal's records; 0 lets detection resume.
// [RQ5] A clear request has no effect on records that are frozen.
// [RQ6] The clear register is eight RW bits, reset 0x00, voltage on odd bits, current on even.
// [RQ7] The freeze register at 0x74 is eight RW bits, reset 0x00, same mapping as clear.
// [RQ8] With deglitch on, a violation qualifies only after two successive positive compares.
// [RQ9] Each channel has five filtered comparators: UV warn, UV crit, OV warn, OV crit, OC warn.
// [RQ10] Each comparator has its own deglitch enable bit, 1 for on and 0 for off.
// [RQ11] The overcurrent filter register at 0x6A resets to 0x00; bits 3..0 are channels 4..1.
// [RQ12] The undervoltage filter register at 0x6B: bit 2n-1 second, bit 2n-2 first comparator.
// [RQ13] The overvoltage filter register at 0x6C: bit 2n-1 second, bit 2n-2 first comparator.
// [RQ14] The action after a qualified violation depends on the comparator and the mode pin.
// [RQ15] Each new sample replaces the maximum when larger and the minimum when smaller.
// [RQ16] Starting a channel loads the reset values into that channel's records.
// [RQ17] With deglitch off one positive compare qualifies; a negative compare restarts the count.
`timescale 1ns/10ps
`include "pdcd_regs.svh"

module pdcd_top
   import pdcd_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int DATA_W = 10
)
(
   input  wire logic           REF_CLK,
   input  wire logic           RST_N,
   input  wire pdcd_reg_req_t  REG_REQ,
   output      logic [7:0]     REG_RDATA,
   input  wire pdcd_sample_t   SAMPLE,
   input  wire logic [3:0]     CHAN_START,
   input  wire logic [3:0]     CMP_VALID,
   input  wire logic [19:0]    CMP_HIT,
   input  wire logic           PROTECTION_MODE_PIN,
   output      logic [19:0]    QUALIFIED,
   output      logic           ALERT,
   output      logic [3:0]     PG_FAIL,
   output      logic [3:0]     SHUTDOWN
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Register widths and address layout are fixed to four channels of 10-bit data
   if (NUM_CH != 4 || DATA_W != 10)
   begin : g_bad_params
      $error("pdcd_top supports only NUM_CH=4 and DATA_W=10");
   end

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // True when the address falls in the min/max record window
   function automatic logic is_rec(input logic [7:0] a);
      is_rec = (a >= `PDCD_REC_FIRST) && (a <= `PDCD_REC_LAST);
   endfunction

   // Signal index of a record byte: 8 bytes per channel, current first then voltage
   function automatic logic [2:0] rec_sig(input logic [7:0] a);
      logic [7:0] o;
      o = a - `PDCD_REC_FIRST;
      rec_sig = {o[4:3], o[2]};
   endfunction

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [7:0] oc_filt_reg, oc_filt_next;
   logic [7:0] uv_filt_reg, uv_filt_next;
   logic [7:0] ov_filt_reg, ov_filt_next;
   logic [7:0] freeze_reg,  freeze_next;
   logic [7:0] clear_reg,   clear_next;
   logic [7:0] rdata_reg,   rdata_next;
   logic [DATA_W-1:0] min_reg [8];
   logic [DATA_W-1:0] max_reg [8];

   // Software writes; reads answer one cycle after the address is presented
   always_comb
   begin
      logic [DATA_W-1:0] v;
      v            = '0;
      oc_filt_next = oc_filt_reg;
      uv_filt_next = uv_filt_reg;
      ov_filt_next = ov_filt_reg;
      freeze_next  = freeze_reg;
      clear_next   = clear_reg;
      if (REG_REQ.wr)
      begin
         unique case (REG_REQ.addr)
            `PDCD_OC_FILT_ADDR: oc_filt_next = REG_REQ.wdata & `PDCD_OC_VALID_MASK; // RQ11
            `PDCD_UV_FILT_ADDR: uv_filt_next = REG_REQ.wdata;                      // RQ12
            `PDCD_OV_FILT_ADDR: ov_filt_next = REG_REQ.wdata;                      // RQ13
            `PDCD_FREEZE_ADDR:  freeze_next  = REG_REQ.wdata;                      // RQ7
            `PDCD_CLEAR_ADDR:   clear_next   = REG_REQ.wdata;                      // RQ6
            default: ;
         endcase
      end
      rdata_next = 8'h00;                  // Unmapped addresses read as zero
      unique case (REG_REQ.addr)
         `PDCD_OC_FILT_ADDR: rdata_next = oc_filt_reg;
         `PDCD_UV_FILT_ADDR: rdata_next = uv_filt_reg;
         `PDCD_OV_FILT_ADDR: rdata_next = ov_filt_reg;
         `PDCD_FREEZE_ADDR:  rdata_next = freeze_reg;
         `PDCD_CLEAR_ADDR:   rdata_next = clear_reg;
         default:
         begin
            if (is_rec(REG_REQ.addr))
            begin
               v = REG_REQ.addr[1] ? max_reg[rec_sig(REG_REQ.addr)]
                                   : min_reg[rec_sig(REG_REQ.addr)];
               rdata_next = REG_REQ.addr[0] ? {6'h00, v[1:0]} : v[9:2];
            end
         end
      endcase
   end

   // Register the control state
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         oc_filt_reg <= `PDCD_CTRL_RESET;
         uv_filt_reg <= `PDCD_CTRL_RESET;
         ov_filt_reg <= `PDCD_CTRL_RESET;
         freeze_reg  <= `PDCD_CTRL_RESET;
         clear_reg   <= `PDCD_CTRL_RESET;
         rdata_reg   <= 8'h00;
      end
      else
      begin
         oc_filt_reg <= oc_filt_next;
         uv_filt_reg <= uv_filt_next;
         ov_filt_reg <= ov_filt_next;
         freeze_reg  <= freeze_next;
         clear_reg   <= clear_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ****************************************************************
   // Peak records
   // ****************************************************************
   logic [DATA_W-1:0] min_next [8];
   logic [DATA_W-1:0] max_next [8];

   // Freeze outranks clear, startup and new samples so a frozen window survives a stray clear
   always_comb
   begin
      logic [2:0] ws;
      ws = rec_sig(REG_REQ.addr);
      for (int s = 0; s < 8; s++)
      begin
         min_next[s] = min_reg[s];
         max_next[s] = max_reg[s];
         if (freeze_reg[s])
         begin
            // Records locked                                              // RQ4 RQ5
         end
         else if (clear_reg[s] || CHAN_START[s/2])
         begin
            min_next[s] = `PDCD_MIN_RESET;                                 // RQ1 RQ2 RQ3 RQ16
            max_next[s] = `PDCD_MAX_RESET;                                 // RQ2
         end
         else if (SAMPLE.valid && SAMPLE.sel == 3'(s))
         begin
            if (SAMPLE.data > max_reg[s])
               max_next[s] = SAMPLE.data;                                  // RQ15
            if (SAMPLE.data < min_reg[s])
               min_next[s] = SAMPLE.data;                                  // RQ15
         end
      end
      // Direct software writes to a record byte land last
      if (REG_REQ.wr && is_rec(REG_REQ.addr))
      begin
         if (REG_REQ.addr[1])
         begin
            if (REG_REQ.addr[0]) max_next[ws][1:0] = REG_REQ.wdata[1:0];
            else                 max_next[ws][9:2] = REG_REQ.wdata;
         end
         else
         begin
            if (REG_REQ.addr[0]) min_next[ws][1:0] = REG_REQ.wdata[1:0];
            else                 min_next[ws][9:2] = REG_REQ.wdata;
         end
      end
   end

   // Register the records
   always_ff @(posedge REF_CLK)
   begin
      for (int s = 0; s < 8; s++)
      begin
         if (!RST_N)
         begin
            min_reg[s] <= `PDCD_MIN_RESET;
            max_reg[s] <= `PDCD_MAX_RESET;
         end
         else
         begin
            min_reg[s] <= min_next[s];
            max_reg[s] <= max_next[s];
         end
      end
   end

   // ****************************************************************
   // Comparator deglitch and actions
   // ****************************************************************
   logic [19:0] prev_hit_reg, prev_hit_next;
   logic [19:0] qual_reg,     qual_next;
   logic        alert_reg,    alert_next;
   logic [3:0]  pgf_reg,      pgf_next;
   logic [3:0]  shut_reg,     shut_next;
   logic [19:0] filt_en;

   // Enable bits in comparator order uv1, uv2, ov1, ov2, oc per channel   // RQ9 RQ10
   always_comb
   begin
      for (int c = 0; c < 4; c++)
      begin
         filt_en[c*5 + `PDCD_CMP_UV1] = uv_filt_reg[2*c];
         filt_en[c*5 + `PDCD_CMP_UV2] = uv_filt_reg[2*c+1];
         filt_en[c*5 + `PDCD_CMP_OV1] = ov_filt_reg[2*c];
         filt_en[c*5 + `PDCD_CMP_OV2] = ov_filt_reg[2*c+1];
         filt_en[c*5 + `PDCD_CMP_OC]  = oc_filt_reg[c];
      end
   end

   // A qualified flag follows each new compare of its channel
   always_comb
   begin
      prev_hit_next = prev_hit_reg;
      qual_next     = qual_reg;
      for (int k = 0; k < 20; k++)
      begin
         if (CMP_VALID[k/5])
         begin
            prev_hit_next[k] = CMP_HIT[k];                                 // RQ17
            qual_next[k] = CMP_HIT[k] && (!filt_en[k] || prev_hit_reg[k]); // RQ8 RQ17
         end
      end
      alert_next = |qual_next;
      for (int c = 0; c < 4; c++)
      begin
         // Critical limits and overcurrent pull power-good; mode pin decides turn-off
         pgf_next[c]  = qual_next[c*5 + `PDCD_CMP_UV2] | qual_next[c*5 + `PDCD_CMP_OV2]
                      | qual_next[c*5 + `PDCD_CMP_OC];                     // RQ14
         shut_next[c] = pgf_next[c] & PROTECTION_MODE_PIN;                 // RQ14
      end
   end

   // Register the comparator state and actions
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         prev_hit_reg <= 20'h00000;
         qual_reg     <= 20'h00000;
         alert_reg    <= 1'b0;
         pgf_reg      <= 4'h0;
         shut_reg     <= 4'h0;
      end
      else
      begin
         prev_hit_reg <= prev_hit_next;
         qual_reg     <= qual_next;
         alert_reg    <= alert_next;
         pgf_reg      <= pgf_next;
         shut_reg     <= shut_next;
      end
   end

   assign QUALIFIED = qual_reg;
   assign ALERT     = alert_reg;
   assign PG_FAIL   = pgf_reg;
   assign SHUTDOWN  = shut_reg;

endmodule

// File: pdcd_checker.sv
// Assertion checker for the peak detect and deglitch top
`timescale 1ns/10ps
module pdcd_checker
   import pdcd_pkg::*;
(
   input wire logic          REF_CLK,
   input wire logic          RST_N,
   input wire pdcd_reg_req_t REG_REQ,
   input wire logic [7:0]    REG_RDATA,
   input wire logic [3:0]    CMP_VALID,
   input wire logic [19:0]   CMP_HIT,
   input wire logic          PROTECTION_MODE_PIN,
   input wire logic [19:0]   QUALIFIED,
   input wire logic          ALERT,
   input wire logic [3:0]    PG_FAIL,
   input wire logic [3:0]    SHUTDOWN
);
   // ****************************************
   // Helper logic and properties
   // ****************************************
   logic [19:0] vmask;
   logic [3:0]  pg_exp;
   // Spread each channel strobe over its five comparators
   always_comb
   begin
      for (int c = 0; c < 4; c++)
      begin
         vmask[c*5 +: 5] = {5{CMP_VALID[c]}};
         pg_exp[c] = QUALIFIED[c*5+1] | QUALIFIED[c*5+3] | QUALIFIED[c*5+4];
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // Reset must clear the read data and the alert even though the other checks are disabled then
   rst_clear_a: assert property (disable iff (1'b0) !RST_N |=> REG_RDATA == 8'h00 && !ALERT)
      else $error("outputs not cleared by reset");
   alert_or_a: assert property (ALERT == (|QUALIFIED))
      else $error("alert differs from OR of qualified");
   pg_map_a: assert property (PG_FAIL == pg_exp)
      else $error("power fail map wrong");
   shut_pg_a: assert property ((SHUTDOWN & ~PG_FAIL) == 4'h0)
      else $error("shutdown without power fail");
   shut_pin_a: assert property (|(SHUTDOWN & ~$past(SHUTDOWN)) |-> $past(PROTECTION_MODE_PIN))
      else $error("shutdown rose with mode pin low");
   // Turn-off follows power fail gated by the mode pin of the cycle before
   shut_mode_a: assert property (1'b1 |=> SHUTDOWN == (PG_FAIL & {4{$past(PROTECTION_MODE_PIN)}}))
      else $error("shutdown differs from power fail and mode pin");
   // A qualified bit needs a positive compare and only moves on its channel strobe
   qual_hit_a: assert property (1'b1 |=> (QUALIFIED & $past(vmask) & ~$past(CMP_HIT)) == 20'h0)
      else $error("qualified without a positive compare");
   qual_hold_a: assert property (1'b1 |=> ((QUALIFIED ^ $past(QUALIFIED)) & ~$past(vmask)) == 20'h0)
      else $error("qualified moved without strobe");
   unmap_rd_a: assert property (REG_REQ.addr == 8'h50 |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   oc_top_a: assert property (REG_REQ.addr == 8'h6A |=> REG_RDATA[7:4] == 4'h0)
      else $error("overcurrent enable upper bits set");
   cover property (|QUALIFIED);
   cover property (|SHUTDOWN);
   cover property (REG_REQ.wr && REG_REQ.addr == 8'h73);
endmodule

bind pdcd_top pdcd_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .CMP_VALID(CMP_VALID), .CMP_HIT(CMP_HIT), .ALERT(ALERT),
   .PROTECTION_MODE_PIN(PROTECTION_MODE_PIN), .QUALIFIED(QUALIFIED), .PG_FAIL(PG_FAIL),
   .SHUTDOWN(SHUTDOWN));

// File: pdcd_tb.sv
// Self-checking bench for the peak detect and deglitch top
`timescale 1ns/10ps
`include "pdcd_regs.svh"
module pdcd_tb
   import pdcd_pkg::*;
;
   logic          REF_CLK, RST_N, PROTECTION_MODE_PIN, ALERT;
   pdcd_reg_req_t REG_REQ;
   pdcd_sample_t  SAMPLE;
   logic [3:0]    CHAN_START, CMP_VALID, PG_FAIL, SHUTDOWN, pg, sh;
   logic [19:0]   CMP_HIT, QUALIFIED, prv, en, q;
   logic [7:0]    REG_RDATA, rd, v, fz, cl, b[3];
   logic [9:0]    mn[8], mx[8];
   int            err_count, compares;
   logic [7:0]    ra[5] = '{`PDCD_OC_FILT_ADDR, `PDCD_UV_FILT_ADDR, `PDCD_OV_FILT_ADDR,
                            `PDCD_CLEAR_ADDR, `PDCD_FREEZE_ADDR};
   pdcd_top dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
      .SAMPLE(SAMPLE), .CHAN_START(CHAN_START), .CMP_VALID(CMP_VALID), .CMP_HIT(CMP_HIT),
      .PROTECTION_MODE_PIN(PROTECTION_MODE_PIN), .QUALIFIED(QUALIFIED), .ALERT(ALERT),
      .PG_FAIL(PG_FAIL), .SHUTDOWN(SHUTDOWN));
   // ****************************************
   // Tasks and expectation functions
   // ****************************************
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Bus calls start and end on a falling edge, so the rising edge takes them cleanly
   // An idle edge after each write keeps back-to-back writes from toggling the strobe at once
   task automatic wr(logic [7:0] a, logic [7:0] d);
      REG_REQ = '{1'b1, a, d};
      @(negedge REF_CLK);
      REG_REQ.wr = 1'b0;
      @(negedge REF_CLK);
   endtask
   task automatic rdb(logic [7:0] a, output logic [7:0] d);
      REG_REQ.addr = a;
      @(negedge REF_CLK);
      d = REG_RDATA;
   endtask
   task automatic chk_rec(int s);
      logic [7:0] h, l;
      rdb(8'h10 + 8'(4*s), h);
      rdb(8'h11 + 8'(4*s), l);
      check("min", {h, l}, {mn[s][9:2], 6'h0, mn[s][1:0]});
      rdb(8'h12 + 8'(4*s), h);
      rdb(8'h13 + 8'(4*s), l);
      check("max", {h, l}, {mx[s][9:2], 6'h0, mx[s][1:0]});
   endtask
   // Record model: freeze beats clear and startup, which beat a new sample
   function automatic void upd(int s);
      if (fz[s])
         return;
      if (cl[s] || CHAN_START[s/2])
      begin
         mn[s] = 10'h3FF;
         mx[s] = 10'h000;
      end
      else if (SAMPLE.valid && SAMPLE.sel == 3'(s))
      begin
         if (SAMPLE.data < mn[s]) mn[s] = SAMPLE.data;
         if (SAMPLE.data > mx[s]) mx[s] = SAMPLE.data;
      end
   endfunction
   function automatic logic [19:0] en_of(logic [7:0] oc, logic [7:0] uv, logic [7:0] ov);
      for (int c = 0; c < 4; c++)
         en_of[c*5 +: 5] = {oc[c], ov[2*c+1], ov[2*c], uv[2*c+1], uv[2*c]};
   endfunction
   // ****************************************
   // Clock, watchdog and test sequence
   // ****************************************
   initial
   begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end
   // Whole run needs about 2000 cycles; allow fifteen times that
   initial
   begin
      #3000000;
      err_count++;
      summarize();
   end
   initial
   begin
      void'($urandom(60));
      {RST_N, REG_REQ, SAMPLE, CHAN_START, CMP_VALID, CMP_HIT, PROTECTION_MODE_PIN} = '0;
      {prv, q, pg, sh, fz, cl} = '0;
      foreach (mn[s]) {mn[s], mx[s]} = {10'h3FF, 10'h000};
      repeat (4) @(negedge REF_CLK);
      RST_N = 1'b1;
      foreach (ra[i])
      begin
         rdb(ra[i], rd);
         check("ctrl_rst", rd, 8'h00);
         v = 8'($urandom);
         wr(ra[i], v);
         rdb(ra[i], rd);
         check("ctrl_rw", rd, (i == 0) ? v & 8'h0F : v);
         wr(ra[i], 8'h00);
      end
      wr(8'h50, 8'hFF);
      rdb(8'h50, rd);
      check("unmapped", rd, 8'h00);
      // Rounds: free running, partly frozen, then clear held against frozen signals
      for (int r = 0; r < 3; r++)
      begin
         fz = (r == 0) ? 8'h00 : 8'($urandom);
         cl = (r == 2) ? 8'($urandom) : 8'h00;
         wr(`PDCD_FREEZE_ADDR, fz);
         wr(`PDCD_CLEAR_ADDR, cl);
         repeat (200)
         begin
            SAMPLE = '{1'($urandom), 3'($urandom), 10'($urandom)};
            CHAN_START = ($urandom_range(0, 19) == 0) ? 4'h1 << $urandom_range(0, 3) : 4'h0;
            for (int s = 0; s < 8; s++) upd(s);
            @(negedge REF_CLK);
         end
         SAMPLE.valid = 1'b0;
         CHAN_START = 4'h0;
         for (int s = 0; s < 8; s++) chk_rec(s);
         wr(`PDCD_CLEAR_ADDR, 8'h00);
         cl = 8'h00;
      end
      // Filter rounds: all off, all on, then two random mixes
      for (int r = 0; r < 4; r++)
      begin
         foreach (b[i]) b[i] = (r == 0) ? 8'h00 : (r == 1) ? 8'hFF : 8'($urandom);
         foreach (b[i]) wr(ra[i], b[i]);
         en = en_of(b[0], b[1], b[2]);
         repeat (300)
         begin
            CMP_VALID = 4'($urandom);
            CMP_HIT = 20'($urandom) | 20'($urandom);
            PROTECTION_MODE_PIN = 1'($urandom);
            for (int i = 0; i < 20; i++)
               if (CMP_VALID[i/5])
               begin
                  q[i] = CMP_HIT[i] & (~en[i] | prv[i]);
                  prv[i] = CMP_HIT[i];
               end
            for (int c = 0; c < 4; c++)
            begin
               pg[c] = q[c*5+1] | q[c*5+3] | q[c*5+4];
               sh[c] = pg[c] & PROTECTION_MODE_PIN;
            end
            @(negedge REF_CLK);
            check("qualified", QUALIFIED, q);
            check("alert", ALERT, |q);
            check("pg_fail", PG_FAIL, pg);
            check("shutdown", SHUTDOWN, sh);
         end
         CMP_VALID = 4'h0;
      end
      summarize();
   end
endmodule
